// ===== flash_dl_pkg.sv
package flash_dl_pkg;

  // register byte addresses on the bus
  localparam logic [7:0] CODE_CTRL_ADDR    = 8'h00;
  localparam logic [7:0] PROG_SEL_ADDR     = 8'h04;
  localparam logic [7:0] ERASE_SEL_ADDR    = 8'h08;
  localparam logic [7:0] KEY_ADDR          = 8'h0c;
  localparam logic [7:0] ARRAY_SEL_ADDR    = 8'h10;
  localparam logic [7:0] DEST_ADDR         = 8'h14;
  localparam logic [7:0] OVERLAY_ADDR      = 8'h18;
  localparam logic [7:0] DL_STATUS_ADDR    = 8'h1c;

  // field positions
  localparam int DL_REQUEST_BIT    = 0;
  localparam int FWE_MON_BIT       = 7;
  localparam int ROUTINE_SEL_BIT   = 0;
  localparam int DEST_ERR_BIT      = 7;
  localparam int OVERLAY_EN_BIT    = 3;
  localparam int RESULT_SS_BIT     = 2;
  localparam int RESULT_FK_BIT     = 1;
  localparam int RESULT_SF_BIT     = 0;
  localparam int STATUS_BUSY_BIT   = 7;

  // key and select values
  localparam logic [7:0] KEY_DOWNLOAD      = 8'ha5;
  localparam logic [7:0] KEY_PROG_ERASE    = 8'h5a;
  localparam logic [7:0] ARRAY_BOOT_VAL    = 8'haa;
  localparam logic [7:0] ARRAY_USER_RST    = 8'h00;
  localparam logic [7:0] REG_RESET         = 8'h00;
  localparam logic [6:0] DEST_LIMIT        = 7'h04;

  // download destinations in on-chip ram
  localparam logic [23:0] DEST_BASE_0      = 24'hff7000;
  localparam logic [23:0] DEST_BASE_1      = 24'hffb000;
  localparam logic [23:0] DEST_BASE_2      = 24'hffd000;
  localparam logic [23:0] DEST_BASE_3      = 24'hffe800;
  localparam logic [11:0] DL_BYTES         = 12'h800;

  // overlay block size shift (4 kbyte blocks)
  localparam int OVERLAY_SHIFT     = 12;

  // axi response codes
  localparam logic [1:0] RESP_OKAY         = 2'h0;
  localparam logic [1:0] RESP_SLVERR       = 2'h2;

  typedef enum logic [1:0] {
    DL_IDLE,
    DL_CHECK,
    DL_COPY,
    DL_RESULT
  } dl_state_t;

endpackage : flash_dl_pkg

// ===== flash_download_mat_emulation_ctrl.sv
// The AXI4-Lite register port and the register offsets were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none

module flash_download_mat_emulation_ctrl (
  // clock, reset, enable
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        clk_en,
  // axi4-lite write
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // axi4-lite read
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // system state
  input  wire logic        cpu_in_ram,
  input  wire logic        user_program_mode,
  input  wire logic        user_boot_mode_pin,
  input  wire logic        fwe_pin,
  input  wire logic        hw_standby_pin,
  // routine rom read port
  output logic [10:0]      rom_addr,
  input  wire logic [7:0]  rom_rd_data,
  // ram write port
  output logic             ram_wr_en,
  output logic [23:0]      ram_wr_addr,
  output logic [7:0]       ram_wr_data,
  // flash control
  output logic             boot_array_sel,
  output logic             prog_erase_en,
  output logic             overlay_en,
  output logic [23:0]      overlay_base,
  output logic             dl_busy
);

  function automatic logic [23:0] dest_base(input logic [1:0] idx);
    case (idx)
      2'h0:    dest_base = flash_dl_pkg::DEST_BASE_0;
      2'h1:    dest_base = flash_dl_pkg::DEST_BASE_1;
      2'h2:    dest_base = flash_dl_pkg::DEST_BASE_2;
      default: dest_base = flash_dl_pkg::DEST_BASE_3;
    endcase
  endfunction : dest_base

  // pin synchronisers; not reset so the strap is settled during reset
  logic [1:0] boot_sync_q;
  logic [1:0] fwe_sync_q;
  logic [1:0] stby_sync_q;
  always_ff @(posedge aclk) begin
    boot_sync_q <= {boot_sync_q[0], user_boot_mode_pin};
    fwe_sync_q  <= {fwe_sync_q[0], fwe_pin};
    stby_sync_q <= {stby_sync_q[0], hw_standby_pin};
  end

  logic clr;
  assign clr = !aresetn || stby_sync_q[1];

  // registers
  logic                    prog_sel_q;
  logic                    erase_sel_q;
  logic [7:0]              key_q;
  logic [7:0]              array_sel_q;
  logic                    dest_err_q;
  logic [6:0]              dest_field_q;
  logic [3:0]              overlay_q;
  logic [2:0]              last_result_q;
  flash_dl_pkg::dl_state_t state_q;
  logic [11:0]             cnt_q;
  logic [23:0]             base_q;
  logic                    ss_err_q;
  logic                    fk_err_q;

  // bus write channel: both address and data taken in one cycle
  logic       wr_take;
  logic [7:0] wr_byte;
  logic       wr_lane;
  assign wr_take = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid && !s_axi_awready;
  assign wr_byte = s_axi_wdata[7:0];
  assign wr_lane = wr_take && s_axi_wstrb[0];

  function automatic logic mapped(input logic [7:0] a);
    mapped = (a[1:0] == 2'h0) && (a <= flash_dl_pkg::DL_STATUS_ADDR);
  endfunction : mapped

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= flash_dl_pkg::RESP_OKAY;
    end else if (clk_en) begin
      s_axi_awready <= wr_take;
      s_axi_wready  <= wr_take;
      if (wr_take) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= mapped(s_axi_awaddr) ? flash_dl_pkg::RESP_OKAY
                                             : flash_dl_pkg::RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // decoded write strobes
  logic wr_ctrl, wr_prog, wr_erase, wr_key, wr_array, wr_dest, wr_ovl;
  assign wr_ctrl  = wr_lane && s_axi_awaddr == flash_dl_pkg::CODE_CTRL_ADDR;
  assign wr_prog  = wr_lane && s_axi_awaddr == flash_dl_pkg::PROG_SEL_ADDR;
  assign wr_erase = wr_lane && s_axi_awaddr == flash_dl_pkg::ERASE_SEL_ADDR;
  assign wr_key   = wr_lane && s_axi_awaddr == flash_dl_pkg::KEY_ADDR;
  assign wr_array = wr_lane && s_axi_awaddr == flash_dl_pkg::ARRAY_SEL_ADDR;
  assign wr_dest  = wr_lane && s_axi_awaddr == flash_dl_pkg::DEST_ADDR;
  assign wr_ovl   = wr_lane && s_axi_awaddr == flash_dl_pkg::OVERLAY_ADDR;

  logic dl_req;
  assign dl_req = wr_ctrl && wr_byte[flash_dl_pkg::DL_REQUEST_BIT]
                  && key_q == flash_dl_pkg::KEY_DOWNLOAD && cpu_in_ram
                  && state_q == flash_dl_pkg::DL_IDLE;

  logic dl_end;
  assign dl_end = state_q == flash_dl_pkg::DL_RESULT;

  // routine selects; completion clears them, a write in that cycle loses
  always_ff @(posedge aclk) begin
    if (clr) begin
      prog_sel_q  <= 1'b0;
      erase_sel_q <= 1'b0;
    end else if (clk_en) begin
      if (dl_end) begin
        prog_sel_q  <= 1'b0;
        erase_sel_q <= 1'b0;
      end else begin
        if (wr_prog)
          prog_sel_q <= wr_byte[flash_dl_pkg::ROUTINE_SEL_BIT];
        if (wr_erase)
          erase_sel_q <= wr_byte[flash_dl_pkg::ROUTINE_SEL_BIT];
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (clr)
      key_q <= flash_dl_pkg::REG_RESET;
    else if (clk_en && wr_key)
      key_q <= wr_byte;
  end

  // strap sampled through the synchroniser while reset is held
  always_ff @(posedge aclk) begin
    if (clr)
      array_sel_q <= boot_sync_q[1] ? flash_dl_pkg::ARRAY_BOOT_VAL
                                    : flash_dl_pkg::ARRAY_USER_RST;
    else if (clk_en && wr_array && cpu_in_ram)
      array_sel_q <= wr_byte;
  end

  // destination; error flag set by the check wins over a clearing write
  always_ff @(posedge aclk) begin
    if (clr) begin
      dest_err_q   <= 1'b0;
      dest_field_q <= 7'h00;
    end else if (clk_en) begin
      if (wr_dest)
        dest_field_q <= wr_byte[6:0];
      if (state_q == flash_dl_pkg::DL_CHECK && dest_field_q >= flash_dl_pkg::DEST_LIMIT)
        dest_err_q <= 1'b1;
      else if (wr_dest)
        dest_err_q <= wr_byte[flash_dl_pkg::DEST_ERR_BIT];
    end
  end

  // only the low four bits are stored, upper bits read zero
  always_ff @(posedge aclk) begin
    if (clr)
      overlay_q <= 4'h0;
    else if (clk_en && wr_ovl)
      overlay_q <= wr_byte[3:0];
  end

  // download sequencer
  always_ff @(posedge aclk) begin
    if (clr) begin
      state_q       <= flash_dl_pkg::DL_IDLE;
      cnt_q         <= 12'h000;
      base_q        <= flash_dl_pkg::DEST_BASE_0;
      ss_err_q      <= 1'b0;
      fk_err_q      <= 1'b0;
      last_result_q <= 3'h0;
    end else if (clk_en) begin
      case (state_q)
        flash_dl_pkg::DL_IDLE: begin
          cnt_q <= 12'h000;
          if (dl_req)
            state_q <= flash_dl_pkg::DL_CHECK;
        end
        flash_dl_pkg::DL_CHECK: begin
          base_q   <= dest_base(dest_field_q[1:0]);
          ss_err_q <= prog_sel_q == erase_sel_q;
          fk_err_q <= key_q != flash_dl_pkg::KEY_DOWNLOAD;
          if (dest_field_q >= flash_dl_pkg::DEST_LIMIT)
            state_q <= flash_dl_pkg::DL_IDLE;
          else if (prog_sel_q == erase_sel_q)
            state_q <= flash_dl_pkg::DL_RESULT;
          else
            state_q <= flash_dl_pkg::DL_COPY;
        end
        flash_dl_pkg::DL_COPY: begin
          if (cnt_q == flash_dl_pkg::DL_BYTES)
            state_q <= flash_dl_pkg::DL_RESULT;
          else
            cnt_q <= cnt_q + 12'h001;
        end
        flash_dl_pkg::DL_RESULT: begin
          last_result_q <= {ss_err_q, fk_err_q, ss_err_q | fk_err_q};
          state_q       <= flash_dl_pkg::DL_IDLE;
        end
        default: state_q <= flash_dl_pkg::DL_IDLE;
      endcase
    end
  end

  // rom address leads the ram write by one cycle to match rom latency
  always_ff @(posedge aclk) begin
    if (clr) begin
      rom_addr    <= 11'h000;
      ram_wr_en   <= 1'b0;
      ram_wr_addr <= 24'h000000;
      ram_wr_data <= 8'h00;
    end else if (clk_en) begin
      ram_wr_en <= 1'b0;
      if (state_q == flash_dl_pkg::DL_COPY) begin
        rom_addr <= cnt_q[10:0];
        if (cnt_q != 12'h000) begin
          ram_wr_en   <= 1'b1;
          ram_wr_addr <= base_q + {12'h000, cnt_q - 12'h001};
          ram_wr_data <= rom_rd_data;
        end
      end else if (dl_end) begin
        ram_wr_en   <= 1'b1;
        // only the result byte is reported, no cpu state is touched
        ram_wr_addr <= base_q;
        ram_wr_data <= {5'h00, ss_err_q, fk_err_q, ss_err_q | fk_err_q};
      end
    end
  end

  // flash control outputs
  always_ff @(posedge aclk) begin
    if (clr) begin
      boot_array_sel <= 1'b0;
      prog_erase_en  <= 1'b0;
      overlay_en     <= 1'b0;
      overlay_base   <= 24'h000000;
      dl_busy        <= 1'b0;
    end else if (clk_en) begin
      boot_array_sel <= array_sel_q == flash_dl_pkg::ARRAY_BOOT_VAL;
      // key, overlay, boot-array guard and the enable pin all must agree
      prog_erase_en  <= key_q == flash_dl_pkg::KEY_PROG_ERASE
                        && !overlay_q[flash_dl_pkg::OVERLAY_EN_BIT]
                        && !(user_program_mode
                             && array_sel_q == flash_dl_pkg::ARRAY_BOOT_VAL)
                        && fwe_sync_q[1];
      overlay_en     <= overlay_q[flash_dl_pkg::OVERLAY_EN_BIT];
      overlay_base   <= {9'h000, overlay_q[2:0], 12'h000};
      dl_busy        <= state_q != flash_dl_pkg::DL_IDLE;
    end
  end

  // bus read channel
  logic [7:0] rd_val;
  always_comb begin
    rd_val = 8'h00;
    case (s_axi_araddr)
      flash_dl_pkg::CODE_CTRL_ADDR:
        rd_val = {fwe_sync_q[1], 7'h00};
      flash_dl_pkg::PROG_SEL_ADDR:  rd_val = {7'h00, prog_sel_q};
      flash_dl_pkg::ERASE_SEL_ADDR: rd_val = {7'h00, erase_sel_q};
      flash_dl_pkg::KEY_ADDR:       rd_val = key_q;
      flash_dl_pkg::ARRAY_SEL_ADDR: rd_val = array_sel_q;
      flash_dl_pkg::DEST_ADDR:      rd_val = {dest_err_q, dest_field_q};
      flash_dl_pkg::OVERLAY_ADDR:   rd_val = {4'h0, overlay_q};
      flash_dl_pkg::DL_STATUS_ADDR:
        rd_val = {state_q != flash_dl_pkg::DL_IDLE, 4'h0, last_result_q};
      default:                      rd_val = 8'h00;
    endcase
  end

  logic [7:0] rd_addr_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= flash_dl_pkg::RESP_OKAY;
      rd_addr_q     <= 8'h00;
    end else if (clk_en) begin
      s_axi_arready <= 1'b0;
      if (s_axi_arvalid && !s_axi_rvalid && !s_axi_arready) begin
        s_axi_arready <= 1'b1;
        s_axi_rvalid  <= 1'b1;
        rd_addr_q     <= s_axi_araddr;
        s_axi_rdata   <= {24'h000000, rd_val};
        s_axi_rresp   <= mapped(s_axi_araddr) ? flash_dl_pkg::RESP_OKAY
                                              : flash_dl_pkg::RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn || stby_sync_q[1]);

  sequence dl_start_s;
    clk_en && state_q == flash_dl_pkg::DL_IDLE ##1 state_q == flash_dl_pkg::DL_CHECK;
  endsequence

  sequence dl_done_s;
    clk_en && state_q == flash_dl_pkg::DL_RESULT;
  endsequence

  request_key_a: assert property (
    dl_start_s |-> $past(key_q) == flash_dl_pkg::KEY_DOWNLOAD && $past(cpu_in_ram))
    else $error("download started without key a5 from ram");

  request_reads_zero_a: assert property (
    s_axi_rvalid && rd_addr_q == flash_dl_pkg::CODE_CTRL_ADDR |-> s_axi_rdata[0] == 1'b0)
    else $error("download request bit read as one");

  dest_abort_a: assert property (
    clk_en && state_q == flash_dl_pkg::DL_CHECK && dest_field_q >= flash_dl_pkg::DEST_LIMIT
      |=> dest_err_q && state_q == flash_dl_pkg::DL_IDLE && !ram_wr_en)
    else $error("bad destination did not abort");

  result_byte_a: assert property (
    dl_done_s |=> ram_wr_en && ram_wr_addr == base_q && ram_wr_data[7:3] == 5'h00)
    else $error("result byte not written at region start");

  select_clear_a: assert property (
    dl_done_s |=> !erase_sel_q && !prog_sel_q)
    else $error("routine select not cleared after transfer");

  key_prog_a: assert property (
    prog_erase_en |-> $past(key_q) == flash_dl_pkg::KEY_PROG_ERASE)
    else $error("program erase enabled without key 5a");

  overlay_guard_a: assert property (
    overlay_en |-> !prog_erase_en)
    else $error("program erase enabled under overlay");

  array_write_a: assert property (
    $changed(array_sel_q) |-> $past(cpu_in_ram))
    else $error("array select changed outside ram execution");

  boot_select_a: assert property (
    clk_en |=> boot_array_sel == ($past(array_sel_q) == flash_dl_pkg::ARRAY_BOOT_VAL))
    else $error("array selection does not follow register");

  overlay_base_a: assert property (
    clk_en |=> overlay_base == {9'h000, $past(overlay_q[2:0]), 12'h000})
    else $error("overlay base wrong for area field");

endmodule : flash_download_mat_emulation_ctrl

`default_nettype wire

// ===== flash_download_mat_emulation_ctrl_tb.sv
`timescale 1ns/100ps
`default_nettype none

module flash_download_mat_emulation_ctrl_tb;

  logic        aclk;
  logic        aresetn;
  logic        clk_en;
  logic [7:0]  s_axi_awaddr;
  logic        s_axi_awvalid;
  logic        s_axi_awready;
  logic [31:0] s_axi_wdata;
  logic [3:0]  s_axi_wstrb;
  logic        s_axi_wvalid;
  logic        s_axi_wready;
  logic [1:0]  s_axi_bresp;
  logic        s_axi_bvalid;
  logic        s_axi_bready;
  logic [7:0]  s_axi_araddr;
  logic        s_axi_arvalid;
  logic        s_axi_arready;
  logic [31:0] s_axi_rdata;
  logic [1:0]  s_axi_rresp;
  logic        s_axi_rvalid;
  logic        s_axi_rready;
  logic        cpu_in_ram;
  logic        user_program_mode;
  logic        user_boot_mode_pin;
  logic        fwe_pin;
  logic        hw_standby_pin;
  logic [10:0] rom_addr;
  logic [7:0]  rom_rd_data;
  logic        ram_wr_en;
  logic [23:0] ram_wr_addr;
  logic [7:0]  ram_wr_data;
  logic        boot_array_sel;
  logic        prog_erase_en;
  logic        overlay_en;
  logic [23:0] overlay_base;
  logic        dl_busy;
  // expected bus answers {resp, rdata} and ram writes {addr, data}
  logic [33:0] bus_q[$];
  logic [31:0] ram_q[$];
  logic [23:0] bases[4];
  logic [23:0] base;
  logic [6:0]  dest;
  logic [2:0]  area;
  int          n_mismatch;
  int          num_checks;
  int          cycles;

  flash_download_mat_emulation_ctrl flash_download_mat_emulation_ctrl_i (
    .aclk, .aresetn, .clk_en,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready,
    .cpu_in_ram, .user_program_mode, .user_boot_mode_pin, .fwe_pin, .hw_standby_pin,
    .rom_addr, .rom_rd_data, .ram_wr_en, .ram_wr_addr, .ram_wr_data,
    .boot_array_sel, .prog_erase_en, .overlay_en, .overlay_base, .dl_busy
  );

  always #12.5 aclk = ~aclk;

  // routine rom read combinationally from rom_addr, no added latency; contents vary per byte so shifts show
  function automatic logic [7:0] rom_byte(input logic [10:0] a);
    return a[7:0] ^ {a[10:8], 5'h15};
  endfunction : rom_byte

  always_comb rom_rd_data = rom_byte(rom_addr);

  task automatic stop_test();
    if (n_mismatch == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : stop_test

  task automatic check(input logic [35:0] seen, input logic [35:0] exp, input string what);
    num_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : check

  // four downloads of 2 kbyte plus bus traffic stay well below this
  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_mismatch++;
      stop_test();
    end
  end

  // watcher: every answer or ram write takes the oldest note
  always @(posedge aclk) begin
    if (aresetn && clk_en
        && ((s_axi_rvalid && s_axi_rready) || (s_axi_bvalid && s_axi_bready))) begin
      if (bus_q.size() == 0) check(36'h1, 36'h0, "bus answer without request");
      else if (s_axi_rvalid) check({2'h0, s_axi_rresp, s_axi_rdata}, {2'h0, bus_q.pop_front()},
                                   "read answer");
      else check({2'h0, s_axi_bresp, 32'h0}, {2'h0, bus_q.pop_front()}, "write answer");
    end
    // a frozen pulse counts once, at the edge where the enable is back
    if (aresetn && clk_en && ram_wr_en) begin
      if (ram_q.size() == 0) check(36'h1, 36'h0, "ram write not expected");
      else check({4'h0, ram_wr_addr, ram_wr_data}, {4'h0, ram_q.pop_front()},
                 "ram write");
    end
  end

  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] resp);
    bus_q.push_back({resp, 32'h0});
    s_axi_awaddr  <= a;
    s_axi_wdata   <= {$urandom_range(0, 0) == 0 ? 24'h0 : 24'h0, d};
    s_axi_wstrb   <= 4'h1;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) begin
        s_axi_awvalid <= 1'b0;
        s_axi_wvalid  <= 1'b0;
      end
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    @(posedge aclk);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] d, input logic [1:0] resp);
    bus_q.push_back({resp, 24'h0, d});
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    @(posedge aclk);
  endtask : rd

  // request a download and wait for the sequencer to go idle again
  task automatic download(input logic [7:0] res, input bit copy);
    if (copy) begin
      for (int k = 0; k < 2048; k++) ram_q.push_back({base + 24'(k), rom_byte(11'(k))});
    end
    // result overwrites the prefilled first byte
    ram_q.push_back({base, res});
    wr(flash_dl_pkg::CODE_CTRL_ADDR, 8'h01, flash_dl_pkg::RESP_OKAY);
    repeat (8) @(posedge aclk);
    // enable low mid-download must freeze the copy
    clk_en <= 1'b0;
    repeat (5) @(posedge aclk);
    clk_en <= 1'b1;
    @(posedge aclk);
    while (dl_busy) @(posedge aclk);
    check(36'(ram_q.size()), 36'h0, "ram writes missing");
  endtask : download

  initial begin
    aclk = 1'b0;
    aresetn = 1'b0;
    clk_en = 1'b1;
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb, s_axi_wvalid} = '0;
    {s_axi_bready, s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
    {user_program_mode, user_boot_mode_pin, hw_standby_pin} = '0;
    cpu_in_ram = 1'b1;
    fwe_pin = 1'b1;
    n_mismatch = 0;
    num_checks = 0;
    cycles = 0;
    bases = '{flash_dl_pkg::DEST_BASE_0, flash_dl_pkg::DEST_BASE_1,
              flash_dl_pkg::DEST_BASE_2, flash_dl_pkg::DEST_BASE_3};
    void'($urandom(89));
    // three edges so the strap synchroniser settles
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(flash_dl_pkg::KEY_ADDR, 8'h00, flash_dl_pkg::RESP_OKAY);
    rd(flash_dl_pkg::ARRAY_SEL_ADDR, flash_dl_pkg::ARRAY_USER_RST, 2'h0);
    rd(flash_dl_pkg::OVERLAY_ADDR, flash_dl_pkg::REG_RESET, 2'h0);
    rd(8'h20, 8'h00, flash_dl_pkg::RESP_SLVERR);
    wr(8'h24, 8'h11, flash_dl_pkg::RESP_SLVERR);
    wr(flash_dl_pkg::KEY_ADDR, flash_dl_pkg::KEY_PROG_ERASE, 2'h0);
    repeat (3) @(posedge aclk);
    check(36'(prog_erase_en), 36'h1, "program enable with key");
    user_program_mode <= 1'b1;
    wr(flash_dl_pkg::ARRAY_SEL_ADDR, flash_dl_pkg::ARRAY_BOOT_VAL, 2'h0);
    repeat (3) @(posedge aclk);
    check(36'(boot_array_sel), 36'h1, "boot array selected");
    check(36'(prog_erase_en), 36'h0, "boot array protected");
    cpu_in_ram <= 1'b0;
    wr(flash_dl_pkg::ARRAY_SEL_ADDR, 8'h00, 2'h0);
    rd(flash_dl_pkg::ARRAY_SEL_ADDR, flash_dl_pkg::ARRAY_BOOT_VAL, 2'h0);
    cpu_in_ram <= 1'b1;
    wr(flash_dl_pkg::ARRAY_SEL_ADDR, 8'hab, 2'h0);
    repeat (3) @(posedge aclk);
    check(36'(boot_array_sel), 36'h0, "user array selected");
    check(36'(prog_erase_en), 36'h1, "user array writable");
    user_program_mode <= 1'b0;
    // overlay area from the random stream; upper bits written as ones on purpose
    area = 3'($urandom);
    wr(flash_dl_pkg::OVERLAY_ADDR, {5'h1f, area}, 2'h0);
    rd(flash_dl_pkg::OVERLAY_ADDR, {5'h01, area}, 2'h0);
    repeat (3) @(posedge aclk);
    check(36'(overlay_en), 36'h1, "overlay on");
    check(36'(overlay_base), {12'h0, 9'h0, area, 12'h0}, "overlay block");
    check(36'(prog_erase_en), 36'h0, "overlay protects flash");
    wr(flash_dl_pkg::OVERLAY_ADDR, {5'h00, area}, 2'h0);
    repeat (3) @(posedge aclk);
    check(36'(overlay_en), 36'h0, "overlay off");
    check(36'(prog_erase_en), 36'h1, "protection lifted");
    wr(flash_dl_pkg::OVERLAY_ADDR, 8'h0f, 2'h0);
    hw_standby_pin <= 1'b1;
    repeat (6) @(posedge aclk);
    hw_standby_pin <= 1'b0;
    repeat (4) @(posedge aclk);
    rd(flash_dl_pkg::OVERLAY_ADDR, 8'h00, 2'h0);
    rd(flash_dl_pkg::KEY_ADDR, 8'h00, 2'h0);
    // request with the program key must not start a copy
    wr(flash_dl_pkg::KEY_ADDR, flash_dl_pkg::KEY_PROG_ERASE, 2'h0);
    wr(flash_dl_pkg::ERASE_SEL_ADDR, 8'h01, 2'h0);
    wr(flash_dl_pkg::CODE_CTRL_ADDR, 8'h01, 2'h0);
    repeat (8) @(posedge aclk);
    check(36'(dl_busy), 36'h0, "download without key");
    rd(flash_dl_pkg::CODE_CTRL_ADDR, 8'h80, 2'h0);
    wr(flash_dl_pkg::KEY_ADDR, flash_dl_pkg::KEY_DOWNLOAD, 2'h0);
    dest = 7'($urandom_range(127, 4));
    wr(flash_dl_pkg::DEST_ADDR, {1'b0, dest}, 2'h0);
    wr(flash_dl_pkg::CODE_CTRL_ADDR, 8'h01, 2'h0);
    repeat (8) @(posedge aclk);
    rd(flash_dl_pkg::DEST_ADDR, {1'b1, dest}, 2'h0);
    for (int d = 0; d < 4; d++) begin
      wr(flash_dl_pkg::DEST_ADDR, 8'(d), 2'h0);
      wr(d[0] ? flash_dl_pkg::PROG_SEL_ADDR : flash_dl_pkg::ERASE_SEL_ADDR, 8'h01, 2'h0);
      base = bases[d];
      download(8'h00, 1'b1);
      rd(flash_dl_pkg::ERASE_SEL_ADDR, 8'h00, 2'h0);
      rd(flash_dl_pkg::PROG_SEL_ADDR, 8'h00, 2'h0);
      rd(flash_dl_pkg::DL_STATUS_ADDR, 8'h00, 2'h0);
    end
    // neither routine, then both: source error, no copy
    for (int s = 0; s < 2; s++) begin
      wr(flash_dl_pkg::PROG_SEL_ADDR, 8'(s), 2'h0);
      wr(flash_dl_pkg::ERASE_SEL_ADDR, 8'(s), 2'h0);
      download(8'h05, 1'b0);
      rd(flash_dl_pkg::DL_STATUS_ADDR, 8'h05, 2'h0);
    end
    // start-up in user boot mode
    user_boot_mode_pin <= 1'b1;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(flash_dl_pkg::ARRAY_SEL_ADDR, flash_dl_pkg::ARRAY_BOOT_VAL, 2'h0);
    repeat (2) @(posedge aclk);
    check(36'(boot_array_sel), 36'h1, "boot array after reset");
    stop_test();
  end

endmodule : flash_download_mat_emulation_ctrl_tb

`default_nettype wire
